// file: common/frt_pkg.sv
package frt_pkg;
  localparam logic [7:0] IDX_CNT_LO  = 8'h20;
  localparam logic [7:0] IDX_CNT_HI  = 8'h21;
  localparam logic [7:0] IDX_CAP_R0  = 8'h22;
  localparam logic [7:0] IDX_CAP_F0  = 8'h23;
  localparam logic [7:0] IDX_CAP_R1  = 8'h24;
  localparam logic [7:0] IDX_CAP_F1  = 8'h25;
  localparam logic [7:0] IDX_STATUS  = 8'h26;
  localparam logic [7:0] IDX_ENABLE  = 8'h27;
  localparam logic [7:0] IDX_CFG     = 8'h2a;

  localparam int         CFG_HOLD_BIT = 7;
  localparam int         CFG_PRE_LSB  = 4;
  localparam int         CFG_JOIN_BIT = 3;
  localparam logic [7:0] CFG_RW_MASK  = 8'hf8;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;

  localparam int FLAG_OVF = 4;
  localparam int FLAG_PER = 5;
  localparam int NFLAGS   = 6;

  localparam int PERIODIC_TIME_US = 1024;
  localparam int SOURCE_MHZ       = 4;
  localparam int PERIODIC_TICKS   = PERIODIC_TIME_US * SOURCE_MHZ;
  localparam logic [15:0] PER_MASK = 16'(PERIODIC_TICKS - 1);

  typedef struct packed {
    logic [15:0]      cnt;
    logic [7:0]       lo_wr;
    logic [7:0]       hi_hold;
    logic [7:0]       cfg;
    logic [3:0][7:0]  cap;
    logic [3:0]       armed;
    logic [NFLAGS-1:0] status;
    logic [NFLAGS-1:0] enable;
    logic             tck_s1;
    logic             tck_s2;
    logic             tck_prev;
    logic [1:0]       cin_s1;
    logic [1:0]       cin_s2;
    logic [1:0]       cin_prev;
    logic [7:0]       dat;
    logic             ack;
  } state_s;

  localparam state_s STATE_RESET = '{
    cnt: CNT_RESET, lo_wr: 8'h00, hi_hold: 8'h00, cfg: CFG_RESET,
    cap: '0, armed: 4'hf, status: '0, enable: '0,
    tck_s1: 1'b0, tck_s2: 1'b0, tck_prev: 1'b0,
    cin_s1: 2'h0, cin_s2: 2'h0, cin_prev: 2'h0, dat: 8'h00, ack: 1'b0};
endpackage : frt_pkg

// file: rtl/free_running_timer_capture.sv
module free_running_timer_capture (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        capture_time_clock_i,
  input  wire logic [1:0]  capture_in_i,
  output logic             irq_o
);
  import frt_pkg::*;

  state_s q;
  state_s d;

  logic       req;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       tick;
  logic [1:0] rise;
  logic [1:0] fall;
  logic       hold;
  logic       join_w;
  logic [2:0] pre;
  logic [7:0] sample;
  logic [3:0] edge_w;
  logic [3:0] load;
  logic [3:0] rd_cap;
  logic       wr_hi;

  assign req    = cyc_i & stb_i & ~q.ack;
  assign wr     = req & we_i & sel_i[0];
  assign rd     = req & ~we_i;
  assign idx    = adr_i[9:2];
  assign wr_hi  = wr & (idx == IDX_CNT_HI);
  // only the second stage of each synchroniser is looked at
  assign tick   = q.tck_s2 & ~q.tck_prev;
  assign rise   = q.cin_s2 & ~q.cin_prev;
  assign fall   = ~q.cin_s2 & q.cin_prev;
  assign hold   = q.cfg[CFG_HOLD_BIT];
  assign join_w = q.cfg[CFG_JOIN_BIT];
  assign pre    = q.cfg[CFG_PRE_LSB +: 3];
  assign sample = 8'(q.cnt >> pre);

  // one slice per capture register: 0 rise ch0, 1 fall ch0, 2 rise ch1, 3 fall ch1
  for (genvar g = 0; g < 4; g++) begin : g_cap
    localparam int SRC      = g / 2;
    localparam bit IS_RISE  = (g % 2 == 0);
    localparam bit LOW_HALF = (g < 2);
    logic own_edge;
    logic base_edge;
    logic armed_w;

    assign own_edge  = IS_RISE ? rise[SRC] : fall[SRC];
    assign base_edge = IS_RISE ? rise[0] : fall[0];
    assign edge_w[g] = join_w ? base_edge : own_edge;
    // joined mode gates capture 1 with its capture 0 partner's arm state
    assign armed_w   = join_w ? q.armed[g % 2] : q.armed[g];
    assign load[g]   = edge_w[g] & (~hold | armed_w);
    assign rd_cap[g] = rd & (idx == 8'(IDX_CAP_R0 + 8'(g)));

    a_load_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      load[g]
      |=> q.status[g])
      else $error("capture load did not set its flag");

    a_flag_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !q.status[g] && !load[g]
      |=> !q.status[g])
      else $error("capture flag set without a load");

    a_recent_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      !join_w && !hold && edge_w[g]
      |=> q.cap[g] == $past(sample))
      else $error("capture did not take the latest edge");

    a_edge_held: assert property (@(posedge clk_i) disable iff (rst_i)
      hold && !armed_w
      |=> $stable(q.cap[g]))
      else $error("disarmed capture was overwritten");

    a_read_rearm: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_cap[g] && !load[g]
      |=> q.armed[g])
      else $error("capture read did not re-arm");

    a_join_byte: assert property (@(posedge clk_i) disable iff (rst_i)
      join_w && load[g]
      |=> q.cap[g] == (LOW_HALF ? $past(q.cnt[7:0]) : $past(q.cnt[15:8])))
      else $error("joined capture byte wrong");

    a_join_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
      join_w && !rise[0] && !fall[0]
      |=> $stable(q.cap[g]))
      else $error("joined capture loaded without a capture 0 edge");

    a_cap_readout: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_cap[g]
      |=> dat_o[7:0] == $past(q.cap[g]))
      else $error("capture read returned wrong value");

    a_cap_static: assert property (@(posedge clk_i) disable iff (rst_i)
      !load[g]
      |=> $stable(q.cap[g]))
      else $error("capture changed without a load");
  end : g_cap

  always_comb begin
    d = q;
    d.ack      = cyc_i & stb_i & ~q.ack;
    d.tck_s1   = capture_time_clock_i;
    d.tck_s2   = q.tck_s1;
    d.tck_prev = q.tck_s2;
    d.cin_s1   = capture_in_i;
    d.cin_s2   = q.cin_s1;
    d.cin_prev = q.cin_s2;

    if (tick) begin
      d.cnt = q.cnt + 16'h0001;
      if (q.cnt == 16'hffff) begin
        d.status[FLAG_OVF] = 1'b1;
      end
      if ((q.cnt & PER_MASK) == PER_MASK) begin
        d.status[FLAG_PER] = 1'b1;
      end
    end

    // a read re-arms its register; a load in the same cycle still wins
    for (int r = 0; r < 4; r++) begin
      if (rd_cap[r]) begin
        d.armed[r] = 1'b1;
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (load[r]) begin
        if (r < 2) begin
          d.cap[r] = join_w ? q.cnt[7:0] : sample;
        end else begin
          d.cap[r] = join_w ? q.cnt[15:8] : sample;
        end
        d.armed[r] = 1'b0;
      end
    end

    if (wr) begin
      unique case (idx)
        IDX_CNT_LO: d.lo_wr = dat_i[7:0];
        IDX_CNT_HI: d.cnt   = {dat_i[7:0], q.lo_wr};
        IDX_CFG:    d.cfg   = dat_i[7:0] & CFG_RW_MASK;
        IDX_ENABLE: d.enable = dat_i[NFLAGS-1:0];
        IDX_STATUS: d.status = d.status & ~(dat_i[NFLAGS-1:0] & q.status);
        default:    d.lo_wr = q.lo_wr;
      endcase
    end

    // set wins over clear: new events are merged after the clear
    d.status[3:0] = d.status[3:0] | load;
    if (tick && q.cnt == 16'hffff) begin
      d.status[FLAG_OVF] = 1'b1;
    end
    if (tick && (q.cnt & PER_MASK) == PER_MASK) begin
      d.status[FLAG_PER] = 1'b1;
    end

    d.dat = 8'h00;
    if (rd) begin
      unique case (idx)
        IDX_CNT_LO: begin
          d.dat     = q.cnt[7:0];
          d.hi_hold = q.cnt[15:8];
        end
        IDX_CNT_HI: d.dat = q.hi_hold;
        IDX_CAP_R0: d.dat = q.cap[0];
        IDX_CAP_F0: d.dat = q.cap[1];
        IDX_CAP_R1: d.dat = q.cap[2];
        IDX_CAP_F1: d.dat = q.cap[3];
        IDX_STATUS: d.dat = 8'(q.status);
        IDX_ENABLE: d.dat = 8'(q.enable);
        IDX_CFG:    d.dat = q.cfg;
        default:    d.dat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign dat_o = {24'h000000, q.dat};
  assign ack_o = q.ack;
  assign irq_o = |(q.status & q.enable);

  a_count_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !wr_hi |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("counter did not advance on tick");

  a_count_commit: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hi |=> q.cnt == {$past(dat_i[7:0]), $past(q.lo_wr)})
    else $error("upper byte write did not commit counter");

  a_high_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_CNT_LO ##1 !(rd && idx == IDX_CNT_LO) [*2]
    |-> q.hi_hold == $past(q.cnt[15:8], 2))
    else $error("holding register lost its sample");

  a_overflow_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && q.cnt == 16'hffff && !wr_hi |=> q.status[FLAG_OVF] && q.cnt == 16'h0000)
    else $error("overflow flag not set on wrap");

  a_cfg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    q.cfg[2:0] == 3'h0)
    else $error("reserved configuration bits nonzero");

  a_first_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    hold && !q.armed[0] && !join_w |=> $stable(q.cap[0]))
    else $error("held capture was overwritten");

  a_join_high: assert property (@(posedge clk_i) disable iff (rst_i)
    join_w && rise[0] && (!hold || q.armed[0]) |=> q.cap[2] == $past(q.cnt[15:8]))
    else $error("joined capture upper byte wrong");

  a_prescale_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    !join_w && rise[1] && !hold |=> q.cap[2] == 8'($past(q.cnt) >> $past(pre)))
    else $error("prescaled capture bits wrong");

  a_sticky_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    q.status[0] && !(wr && idx == IDX_STATUS && dat_i[0]) |=> q.status[0])
    else $error("capture flag dropped without clear");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_count_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick && !wr_hi
    |=> $stable(q.cnt))
    else $error("counter moved without a tick");

  a_tick_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    tick
    |-> $past(capture_time_clock_i, 2))
    else $error("tick not taken from the synchronised clock");

  a_periodic_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && (q.cnt & PER_MASK) == PER_MASK
    |=> q.status[FLAG_PER])
    else $error("periodic flag not set");

  a_per_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    q.status[FLAG_PER] && !(wr && idx == IDX_STATUS && dat_i[FLAG_PER])
    |=> q.status[FLAG_PER])
    else $error("periodic flag dropped without clear");

  a_per_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.status[FLAG_PER] && !(tick && (q.cnt & PER_MASK) == PER_MASK)
    |=> !q.status[FLAG_PER])
    else $error("periodic flag set off period");

  a_ovf_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    q.status[FLAG_OVF] && !(wr && idx == IDX_STATUS && dat_i[FLAG_OVF])
    |=> q.status[FLAG_OVF])
    else $error("overflow flag dropped without clear");

  a_ovf_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.status[FLAG_OVF] && !(tick && q.cnt == 16'hffff)
    |=> !q.status[FLAG_OVF])
    else $error("overflow flag set without a wrap");

  a_low_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_CNT_LO
    |=> dat_o[7:0] == $past(q.cnt[7:0]) && q.hi_hold == $past(q.cnt[15:8]))
    else $error("low byte read did not sample the counter");

  a_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_CNT_HI
    |=> dat_o[7:0] == $past(q.hi_hold))
    else $error("upper byte read not from holding register");

  a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !(rd && idx == IDX_CNT_LO)
    |=> $stable(q.hi_hold))
    else $error("holding register changed without low read");

  a_low_held: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CNT_LO
    |=> q.lo_wr == $past(dat_i[7:0]))
    else $error("low byte write not held");

  a_low_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && idx == IDX_CNT_LO)
    |=> $stable(q.lo_wr))
    else $error("held low byte changed without write");

  a_reset_values: assert property (@(posedge clk_i)
    $fell(rst_i)
    |-> q.cnt == CNT_RESET && q.cfg == CFG_RESET && q.hi_hold == 8'h00 && !ack_o && !irq_o)
    else $error("register not at reset value");

  a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CFG
    |=> q.cfg[7:3] == $past(dat_i[7:3]))
    else $error("configuration write not taken");

  a_cfg_readout: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_CFG
    |=> dat_o[7:0] == $past(q.cfg))
    else $error("configuration read returned wrong value");

  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o
    |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  a_data_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o
    |-> dat_o == 32'h00000000)
    else $error("read data present without ack");

  a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx > IDX_CFG
    |=> dat_o == 32'h00000000)
    else $error("unmapped read returned nonzero");

  a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_STATUS && dat_i[0] && !load[0]
    |=> !q.status[0])
    else $error("status write one did not clear flag");

  a_status_readout: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == IDX_STATUS
    |=> dat_o[7:0] == 8'($past(q.status)))
    else $error("status read returned wrong value");

  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_ENABLE
    |=> q.enable == $past(dat_i[NFLAGS-1:0]))
    else $error("enable write not taken");

  a_sync_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    rise[0]
    |-> $past(capture_in_i[0], 2))
    else $error("rising edge seen without synchronised input");

  a_sync_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    fall[1]
    |-> !$past(capture_in_i[1], 2))
    else $error("falling edge seen without synchronised input");
endmodule : free_running_timer_capture

// file: bench/edge_source.sv
module edge_source (
  input  wire logic       clk_i,
  output logic            tick_o,
  output logic [1:0]      cin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tick_o = 1'b0;
    cin_o  = 2'h0;
  end
  // each phase lasts 4 cycles so the 2-flop sampler never misses a tick
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      tick_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : tick
  // settle time covers the synchroniser and edge detector
  task automatic edge_to(input int ch, input logic lvl);
    @(posedge clk_i);
    cin_o[ch] <= lvl;
    repeat (6) @(posedge clk_i);
  endtask : edge_to
endmodule : edge_source

// file: bench/free_running_timer_capture_bench.sv
module free_running_timer_capture_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import frt_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  sel;
  logic [9:0]  adr;
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        tick;
  logic [1:0]  cin;
  logic        irq_o;
  int          error_cnt;
  int          checked;
  logic [7:0]  r;
  logic [15:0] v;

  always #50 clk_i = ~clk_i;

  free_running_timer_capture uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .capture_time_clock_i(tick), .capture_in_i(cin), .irq_o(irq_o));
  edge_source p (.clk_i(clk_i), .tick_o(tick), .cin_o(cin));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request stands until the rising edge that samples ack; data taken and released there
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'h1;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      error_cnt++;
      end_sim();
    end else begin
      r = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask : acc

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(r, exp);
  endtask : rdc

  task automatic setcnt(input logic [15:0] c);
    acc(1'b1, IDX_CNT_LO, c[7:0]);
    acc(1'b1, IDX_CNT_HI, c[15:8]);
  endtask : setcnt

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 10'h000;
    wdat = 32'h0;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(IDX_CNT_HI, 8'h00);
    rdc(IDX_CFG, 8'h00);
    rdc(8'h3f, 8'h00);
    acc(1'b1, IDX_CFG, 8'hff);
    rdc(IDX_CFG, CFG_RW_MASK);
    $display("test reset done");
    setcnt(16'h1234);
    acc(1'b1, IDX_CNT_LO, 8'h77);
    rdc(IDX_CNT_LO, 8'h34);
    rdc(IDX_CNT_HI, 8'h12);
    setcnt(16'h12ff);
    rdc(IDX_CNT_LO, 8'hff);
    p.tick(1);
    rdc(IDX_CNT_HI, 8'h12);
    rdc(IDX_CNT_LO, 8'h00);
    rdc(IDX_CNT_HI, 8'h13);
    $display("test counter done");
    for (int n = 0; n < 8; n++) begin
      v = 16'ha5c3 + 16'(n) * 16'h0123;
      acc(1'b1, IDX_CFG, {1'b0, 3'(n), 4'h0});
      setcnt(v);
      p.edge_to(0, 1'b1);
      rdc(IDX_CAP_R0, 8'(v >> n));
      p.edge_to(0, 1'b0);
      rdc(IDX_CAP_F0, 8'(v >> n));
    end
    acc(1'b1, IDX_CFG, 8'h00);
    setcnt(16'h0011);
    p.edge_to(0, 1'b1);
    setcnt(16'h0022);
    p.edge_to(0, 1'b0);
    p.edge_to(0, 1'b1);
    rdc(IDX_CAP_R0, 8'h22);
    $display("test prescale done");
    acc(1'b1, IDX_CFG, 8'h80);
    acc(1'b0, IDX_CAP_R0, 8'h00);
    setcnt(16'h0033);
    p.edge_to(0, 1'b0);
    p.edge_to(0, 1'b1);
    setcnt(16'h0044);
    p.edge_to(0, 1'b0);
    p.edge_to(0, 1'b1);
    rdc(IDX_CAP_R0, 8'h33);
    p.edge_to(0, 1'b0);
    p.edge_to(0, 1'b1);
    rdc(IDX_CAP_R0, 8'h44);
    $display("test hold done");
    acc(1'b1, IDX_CFG, 8'h08);
    setcnt(16'h1122);
    p.edge_to(1, 1'b1);
    rdc(IDX_CAP_R1, 8'h00);
    setcnt(16'hbeef);
    p.edge_to(0, 1'b0);
    rdc(IDX_CAP_F0, 8'hef);
    rdc(IDX_CAP_F1, 8'hbe);
    acc(1'b1, IDX_CFG, 8'h00);
    setcnt(16'h0042);
    p.edge_to(1, 1'b0);
    rdc(IDX_CAP_F1, 8'h42);
    acc(1'b1, IDX_CFG, 8'h30);
    p.edge_to(1, 1'b1);
    rdc(IDX_CAP_R1, 8'h08);
    $display("test join done");
    acc(1'b1, IDX_STATUS, 8'hff);
    rdc(IDX_STATUS, 8'h00);
    acc(1'b1, IDX_ENABLE, 8'h02);
    setcnt(16'h0055);
    p.edge_to(0, 1'b1);
    rdc(IDX_STATUS, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    acc(1'b1, IDX_ENABLE, 8'h01);
    rdc(IDX_ENABLE, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    acc(1'b1, IDX_STATUS, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    setcnt(16'hffff);
    p.tick(1);
    rdc(IDX_STATUS, 8'h30);
    acc(1'b1, IDX_STATUS, 8'hff);
    setcnt(16'h0fff);
    p.tick(1);
    rdc(IDX_STATUS, 8'h20);
    $display("test status done");
    end_sim();
  end
endmodule : free_running_timer_capture_bench
